/* bsx_alu.sv */
// Xor unit with pass-through for moves and zero detect
`timescale 1ns/1ps
`default_nettype none
module bsx_alu (
  bsx_alu_if.alu port_a
);
  always_comb begin
    port_a.result = port_a.pass ? port_a.operand : (port_a.work ^ port_a.operand);
    port_a.zero   = (port_a.result == 8'h00);
  end
endmodule // bsx_alu
`default_nettype wire

/* bsx_alu_if.sv */
// Interface: operands and result between the sequencer and the xor unit
`timescale 1ns/1ps
`default_nettype none
interface bsx_alu_if;
  logic [7:0] work;
  logic [7:0] operand;
  logic       pass;
  logic [7:0] result;
  logic       zero;
  modport core (output work, output operand, output pass, input result, input zero);
  modport alu  (input work, input operand, input pass, output result, output zero);
endinterface
`default_nettype wire

/* bsx_exec.sv */
// Execution of bank-load, literal xor, register xor and low-page move
// How it works
// - bank-load writes literal into low bank bits
// - upper four bank bits stay unchanged
// - bank-load is 1011 1000 uuuu kkkk
// - one word, literal read Q2, written Q4
// - literal xor updates working register and zero
// - register xor with d=0 writes working register
// - d=1 writes file, working register kept
// - move copies source to destination, source kept
// - move source 00h-FFh, destination 00h-1Fh
`timescale 1ns/1ps
`default_nettype none
module bsx_exec (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        instr_valid,
  input  wire logic [15:0] instr,
  input  wire logic [7:0]  file_rdata,
  output logic [7:0]       file_addr,
  output logic [7:0]       file_wdata,
  output logic             file_we,
  output logic [7:0]       working_reg,
  output logic [7:0]       bank_select_reg,
  output logic             zero_flag,
  output logic [1:0]       quarter
);

  bsx_pkg::bsx_state_type state_reg;
  bsx_pkg::bsx_state_type state_next;
  bsx_alu_if              alu_bus ();

  bsx_alu u_alu (
    .port_a (alu_bus.alu)
  );

  assign alu_bus.work    = state_reg.work;
  assign alu_bus.operand = state_reg.operand;
  assign alu_bus.pass    = (state_reg.op == bsx_pkg::OP_MOVE);

  always_comb begin
    state_next         = state_reg;
    state_next.file_we = 1'b0;
    case (state_reg.q)
      bsx_pkg::Q1: begin
        // Decode; bits 7:4 of the bank-load word are latched into lit and file_addr but masked off before the operand
        state_next.q         = bsx_pkg::Q2;
        state_next.op        = instr_valid ? bsx_pkg::bsx_decode(instr)
                                           : bsx_pkg::OP_NONE;
        state_next.lit       = instr[7:0];
        state_next.paddr     = instr[bsx_pkg::PAGE_MSB:bsx_pkg::PAGE_LSB];
        state_next.to_file   = instr[bsx_pkg::DEST_BIT];
        state_next.file_addr = instr[7:0];
      end
      bsx_pkg::Q2: begin
        state_next.q = bsx_pkg::Q3;
        case (state_reg.op)
          bsx_pkg::OP_XORF,
          bsx_pkg::OP_MOVE: state_next.operand = file_rdata;
          bsx_pkg::OP_BANK: state_next.operand = {4'h0, state_reg.lit[3:0]};
          default:          state_next.operand = state_reg.lit;
        endcase
      end
      bsx_pkg::Q3: begin
        state_next.q          = bsx_pkg::Q4;
        state_next.result     = alu_bus.result;
        state_next.zres       = alu_bus.zero;
        state_next.file_wdata = alu_bus.result;
        if (state_reg.op == bsx_pkg::OP_MOVE) begin
          // Destination is forced into the low page
          state_next.file_we   = 1'b1;
          state_next.file_addr = {bsx_pkg::PAGE_HIGH, state_reg.paddr};
        end else if (state_reg.op == bsx_pkg::OP_XORF && state_reg.to_file) begin
          state_next.file_we = 1'b1;
        end
      end
      bsx_pkg::Q4: begin
        state_next.q = bsx_pkg::Q1;
        case (state_reg.op)
          bsx_pkg::OP_BANK: state_next.bank = {state_reg.bank[7:4],
                                               state_reg.operand[3:0]};
          bsx_pkg::OP_XORL: begin
            state_next.work = state_reg.result;
            state_next.zero = state_reg.zres;
          end
          bsx_pkg::OP_XORF: begin
            if (!state_reg.to_file)
              state_next.work = state_reg.result;
            state_next.zero = state_reg.zres;
          end
          default: ;
        endcase
      end
      default: state_next.q = bsx_pkg::Q1;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n)
      state_reg <= bsx_pkg::ST_RST;
    else
      state_reg <= state_next;
  end

  assign file_addr       = state_reg.file_addr;
  assign file_wdata      = state_reg.file_wdata;
  assign file_we         = state_reg.file_we;
  assign working_reg     = state_reg.work;
  assign bank_select_reg = state_reg.bank;
  assign zero_flag       = state_reg.zero;
  assign quarter         = state_reg.q;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence s_take(bsx_pkg::bsx_op_type op);
    (state_reg.q == bsx_pkg::Q1) && instr_valid && (bsx_pkg::bsx_decode(instr) == op);
  endsequence

  property p_bank_low;
    s_take(bsx_pkg::OP_BANK) |-> ##4 (bank_select_reg[3:0] == $past(instr[3:0], 4));
  endproperty
  a_bank_low: assert property (p_bank_low) else $error("bank low nibble wrong");

  property p_bank_high;
    s_take(bsx_pkg::OP_BANK) |-> ##4 (bank_select_reg[7:4] == $past(bank_select_reg[7:4], 4));
  endproperty
  a_bank_high: assert property (p_bank_high) else $error("bank high nibble moved");

  property p_bank_decode;
    (state_reg.q == bsx_pkg::Q1) && instr_valid && (instr[15:8] == bsx_pkg::BANK_OPC)
      |=> (state_reg.op == bsx_pkg::OP_BANK);
  endproperty
  a_bank_decode: assert property (p_bank_decode) else $error("bank-load not decoded");

  property p_bank_timing;
    s_take(bsx_pkg::OP_BANK) |-> ##1 $stable(bank_select_reg)[*3] ##1 (quarter == bsx_pkg::Q1);
  endproperty
  a_bank_timing: assert property (p_bank_timing) else $error("bank write not at Q4");

  property p_xorl;
    s_take(bsx_pkg::OP_XORL)
      |-> ##4 (working_reg == ($past(working_reg, 4) ^ $past(instr[7:0], 4)));
  endproperty
  a_xorl: assert property (p_xorl) else $error("literal xor result wrong");

  property p_xorf_work;
    s_take(bsx_pkg::OP_XORF) ##0 !instr[bsx_pkg::DEST_BIT]
      |-> ##4 (working_reg == ($past(working_reg, 4) ^ $past(file_rdata, 3)));
  endproperty
  a_xorf_work: assert property (p_xorf_work) else $error("register xor to work wrong");

  property p_xorf_file;
    s_take(bsx_pkg::OP_XORF) ##0 instr[bsx_pkg::DEST_BIT]
      |-> ##3 (file_we && file_addr == $past(instr[7:0], 3)
               && file_wdata == ($past(working_reg, 3) ^ $past(file_rdata, 2)))
          ##1 $stable(working_reg);
  endproperty
  a_xorf_file: assert property (p_xorf_file) else $error("register xor to file wrong");

  property p_move;
    s_take(bsx_pkg::OP_MOVE)
      |-> ##3 (file_we && file_addr == {bsx_pkg::PAGE_HIGH, $past(instr[12:8], 3)}
               && file_wdata == $past(file_rdata, 2));
  endproperty
  a_move: assert property (p_move) else $error("move write wrong");

  property p_zero_xorl;
    s_take(bsx_pkg::OP_XORL)
      |-> ##4 (zero_flag == ($past(instr[7:0], 4) == $past(working_reg, 4)));
  endproperty
  a_zero_xorl: assert property (p_zero_xorl) else $error("zero flag wrong");

  property p_zero_kept;
    s_take(bsx_pkg::OP_MOVE) or s_take(bsx_pkg::OP_BANK) |-> ##4 $stable(zero_flag);
  endproperty
  a_zero_kept: assert property (p_zero_kept) else $error("zero flag disturbed");

  property p_write_q4;
    file_we |-> (quarter == bsx_pkg::Q4) ##1 !file_we;
  endproperty
  a_write_q4: assert property (p_write_q4) else $error("file write outside Q4");

  sequence s_walk;
    (quarter == bsx_pkg::Q2) ##1 (quarter == bsx_pkg::Q3) ##1 (quarter == bsx_pkg::Q4);
  endsequence

  property p_quarter_walk;
    (quarter == bsx_pkg::Q1) |=> s_walk ##1 (quarter == bsx_pkg::Q1);
  endproperty
  a_quarter_walk: assert property (p_quarter_walk) else $error("bad quarter");

  property p_zero_xorf;
    s_take(bsx_pkg::OP_XORF)
      |-> ##4 (zero_flag == (($past(working_reg, 4) ^ $past(file_rdata, 3)) == 8'h00));
  endproperty
  a_zero_xorf: assert property (p_zero_xorf) else $error("xor zero wrong");

  property p_move_work;
    s_take(bsx_pkg::OP_MOVE) |-> ##4 (working_reg == $past(working_reg, 4));
  endproperty
  a_move_work: assert property (p_move_work) else $error("move touched work");

  // Refused words must leave every register alone
  property p_idle;
    (state_reg.q == bsx_pkg::Q1) && (!instr_valid || bsx_pkg::bsx_decode(instr) == bsx_pkg::OP_NONE)
      |-> ##3 !file_we
          ##1 ($stable(working_reg) && $stable(bank_select_reg) && $stable(zero_flag));
  endproperty
  a_idle: assert property (p_idle) else $error("refused word acted");

  property p_xorl_no_write;
    s_take(bsx_pkg::OP_XORL) |-> ##3 !file_we ##1 $stable(bank_select_reg);
  endproperty
  a_xorl_no_write: assert property (p_xorl_no_write) else $error("stray write");

  property p_bank_operand;
    s_take(bsx_pkg::OP_BANK) |-> ##2 (state_reg.operand == {4'h0, $past(instr[3:0], 2)});
  endproperty
  a_bank_operand: assert property (p_bank_operand) else $error("literal not read");

endmodule // bsx_exec
`default_nettype wire

/* bsx_pkg.sv */
// Package: encodings, reset values and state types of the bank/xor execution block
package bsx_pkg;

  localparam logic [7:0] BANK_OPC  = 8'hB8;   // Bits 15:8 of the bank-load word
  localparam logic [7:0] XORL_OPC  = 8'hB4;   // Bits 15:8 of the literal xor word
  localparam logic [6:0] XORF_OPC  = 7'h06;   // Bits 15:9 of the register xor word
  localparam logic [2:0] MOVE_OPC  = 3'h3;    // Bits 15:13 of the move word
  localparam int         DEST_BIT  = 8;       // Destination select of the register xor
  localparam int         PAGE_MSB  = 12;      // Move destination field 12:8
  localparam int         PAGE_LSB  = 8;
  localparam logic [2:0] PAGE_HIGH = 3'h0;    // Move destination lives in 00h..1Fh
  localparam logic [7:0] WORK_RST  = 8'h00;
  localparam logic [7:0] BANK_RST  = 8'h00;
  localparam logic       ZERO_RST  = 1'b0;

  typedef enum logic [1:0] {
    Q1 = 2'b00,
    Q2 = 2'b01,
    Q3 = 2'b10,
    Q4 = 2'b11
  } bsx_quarter_type;

  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_BANK = 3'b001,
    OP_XORL = 3'b010,
    OP_XORF = 3'b011,
    OP_MOVE = 3'b100
  } bsx_op_type;

  typedef struct packed {
    bsx_quarter_type q;
    bsx_op_type      op;
    logic [7:0]      lit;
    logic [4:0]      paddr;
    logic            to_file;
    logic [7:0]      operand;
    logic [7:0]      result;
    logic            zres;
    logic [7:0]      work;
    logic [7:0]      bank;
    logic            zero;
    logic            file_we;
    logic [7:0]      file_addr;
    logic [7:0]      file_wdata;
  } bsx_state_type;

  localparam bsx_state_type ST_RST = '{q: Q1, op: OP_NONE, lit: 8'h00, paddr: 5'h00,
    to_file: 1'b0, operand: 8'h00, result: 8'h00, zres: 1'b0, work: WORK_RST,
    bank: BANK_RST, zero: ZERO_RST, file_we: 1'b0, file_addr: 8'h00, file_wdata: 8'h00};

  // Bits 7:4 of the bank-load word are don't care
  function automatic bsx_op_type bsx_decode(input logic [15:0] word);
    if (word[15:8] == BANK_OPC)
      return OP_BANK;
    else if (word[15:8] == XORL_OPC)
      return OP_XORL;
    else if (word[15:9] == XORF_OPC)
      return OP_XORF;
    else if (word[15:13] == MOVE_OPC)
      return OP_MOVE;
    else
      return OP_NONE;
  endfunction

endpackage

/* tb_bank_select_and_xor_exec.sv */
// Testbench: self-checking scenarios for the bank/xor execution block
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin fails++; \
  $display("BAD t=%0t got=%h exp=%h", $time, got, exp); end end
module tb_bank_select_and_xor_exec;
  logic        mclk;
  logic        rst_n;
  logic        instr_valid;
  logic [15:0] instr;
  logic [7:0]  file_rdata;
  logic [7:0]  file_addr;
  logic [7:0]  file_wdata;
  logic        file_we;
  logic [7:0]  working_reg;
  logic [7:0]  bank_select_reg;
  logic        zero_flag;
  logic [1:0]  quarter;
  logic [7:0]  mem [0:255];
  logic        we_q4;
  logic [7:0]  wa;
  logic [7:0]  wd;
  int          fails;
  int          checked;
  int          cycles;

  bsx_exec uut (.mclk(mclk), .rst_n(rst_n), .instr_valid(instr_valid), .instr(instr),
    .file_rdata(file_rdata), .file_addr(file_addr), .file_wdata(file_wdata),
    .file_we(file_we), .working_reg(working_reg), .bank_select_reg(bank_select_reg),
    .zero_flag(zero_flag), .quarter(quarter));

  // Data memory with combinational read, written at the edge ending the strobe
  assign file_rdata = mem[file_addr];
  always @(posedge mclk) begin
    if (file_we)
      mem[file_addr] <= file_wdata;
  end

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // Whole run is under 200 cycles; generous ceiling
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 1000) begin
      fails++;
      complete_run();
    end
  end

  // One instruction, presented for a Q1 edge; write strobe captured in Q4
  task automatic run(input logic [15:0] word, input logic v);
    `CHK(quarter, 2'h0)
    instr = word;
    instr_valid = v;
    @(posedge mclk);
    #1;
    instr_valid = 1'b0;
    instr = 16'h0000;
    repeat (2) @(posedge mclk);
    #1;
    we_q4 = file_we;
    wa = file_addr;
    wd = file_wdata;
    @(posedge mclk);
    #1;
    `CHK(file_we, 1'b0)
  endtask

  task automatic t_bank;
    for (int k = 0; k < 16; k++) begin
      run({8'hB8, 4'h0, 4'(k)}, 1'b1);
      `CHK(bank_select_reg, {4'h0, 4'(k)})
      `CHK(we_q4, 1'b0)
    end
    // Not valid: nothing may change
    run(16'hB803, 1'b0);
    `CHK(bank_select_reg, 8'h0F)
    // Unknown opcode is a no-op
    run(16'hFF03, 1'b1);
    `CHK(bank_select_reg, 8'h0F)
    $display("test bank done");
  endtask

  task automatic t_xorl;
    run(16'hB4B5, 1'b1);
    `CHK(working_reg, 8'hB5)
    `CHK(zero_flag, 1'b0)
    run(16'hB4AF, 1'b1);
    `CHK(working_reg, 8'h1A)
    run(16'hB41A, 1'b1);
    `CHK(working_reg, 8'h00)
    `CHK(zero_flag, 1'b1)
    `CHK(we_q4, 1'b0)
    `CHK(bank_select_reg, 8'h0F)
    $display("test literal xor done");
  endtask

  task automatic t_xorf;
    run(16'hB4B5, 1'b1);
    mem[8'h40] = 8'hAF;
    run(16'h0D40, 1'b1);
    `CHK({we_q4, wa, wd}, {1'b1, 8'h40, 8'h1A})
    `CHK(mem[8'h40], 8'h1A)
    `CHK(working_reg, 8'hB5)
    `CHK(zero_flag, 1'b0)
    mem[8'h41] = 8'hB5;
    run(16'h0C41, 1'b1);
    `CHK(working_reg, 8'h00)
    `CHK(zero_flag, 1'b1)
    `CHK(we_q4, 1'b0)
    `CHK(mem[8'h41], 8'hB5)
    mem[8'h42] = 8'hFF;
    run(16'h0C42, 1'b1);
    `CHK(working_reg, 8'hFF)
    `CHK(zero_flag, 1'b0)
    $display("test register xor done");
  endtask

  task automatic t_move;
    // Zero set first so a move that touched it would show
    run(16'hB4FF, 1'b1);
    `CHK(zero_flag, 1'b1)
    mem[8'hC5] = 8'h5A;
    mem[8'h1F] = 8'h11;
    run(16'h7FC5, 1'b1);
    `CHK({we_q4, wa, wd}, {1'b1, 8'h1F, 8'h5A})
    `CHK(mem[8'h1F], 8'h5A)
    `CHK(mem[8'hC5], 8'h5A)
    `CHK(zero_flag, 1'b1)
    run(16'h60C5, 1'b1);
    `CHK({we_q4, wa}, {1'b1, 8'h00})
    `CHK(mem[8'h00], 8'h5A)
    `CHK(working_reg, 8'h00)
    $display("test move done");
  endtask

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial begin
    rst_n = 1'b0;
    instr_valid = 1'b0;
    instr = 16'h0000;
    fails = 0;
    checked = 0;
    cycles = 0;
    for (int i = 0; i < 256; i++)
      mem[i] = 8'(i);
    repeat (16) @(posedge mclk);
    #1;
    `CHK({working_reg, bank_select_reg, zero_flag, file_we, quarter}, 20'h00000)
    rst_n = 1'b1;
    t_bank();
    t_xorl();
    t_xorf();
    t_move();
    complete_run();
  end
endmodule // tb_bank_select_and_xor_exec
`default_nettype wire
